// ==== include/ldst_ext_pkg.sv ====
// Package with encodings, states and constants for the custom load/store decode block.
package ldst_ext_pkg;
  localparam logic [6:0] OPC_CUSTOM_LD = 7'h0b;   // Post-increment load opcode 0001011.
  localparam logic [6:0] OPC_LOAD      = 7'h03;   // Standard load opcode 0000011.
  localparam logic [6:0] OPC_CUSTOM_ST = 7'h2b;   // Post-increment store opcode 0101011.
  localparam logic [6:0] OPC_STORE     = 7'h23;   // Standard store opcode 0100011.
  localparam logic [2:0] F3_LB         = 3'h0;    // Signed byte.
  localparam logic [2:0] F3_LH         = 3'h1;    // Signed half.
  localparam logic [2:0] F3_LW         = 3'h2;    // Word.
  localparam logic [2:0] F3_LBU        = 3'h4;    // Unsigned byte.
  localparam logic [2:0] F3_LHU        = 3'h5;    // Unsigned half.
  localparam logic [2:0] F3_ELW        = 3'h6;    // Event load word.
  localparam logic [2:0] F3_REG        = 3'h7;    // Register-offset load forms.
  localparam logic [2:0] F3_SB_REG     = 3'h4;    // Register-offset byte store.
  localparam logic [2:0] F3_SH_REG     = 3'h5;    // Register-offset half store.
  localparam logic [2:0] F3_SW_REG     = 3'h6;    // Register-offset word store.
  localparam logic [6:0] F7_LB         = 7'h00;   // Register-offset signed byte.
  localparam logic [6:0] F7_LBU        = 7'h20;   // Register-offset unsigned byte.
  localparam logic [6:0] F7_LH         = 7'h08;   // Register-offset signed half.
  localparam logic [6:0] F7_LHU        = 7'h28;   // Register-offset unsigned half.
  localparam logic [6:0] F7_LW         = 7'h10;   // Register-offset word.
  localparam logic [6:0] F7_ZERO       = 7'h00;   // Upper bits of register stores.
  localparam logic [1:0] SIZE_BYTE     = 2'h0;    // Access size byte.
  localparam logic [1:0] SIZE_HALF     = 2'h1;    // Access size half.
  localparam logic [1:0] SIZE_WORD     = 2'h2;    // Access size word.
  // Execution phases of one instruction.
  typedef enum logic [1:0] {
    st_idle,
    st_mem,
    st_base_wb
  } phase_t;
endpackage

// ==== core/ldst_extend.sv ====
// Load data extractor that aligns and sign or zero extends a load result.
module ldst_extend
  import ldst_ext_pkg::*;
(
  input  wire logic [31:0] raw_data,
  input  wire logic [1:0]  byte_offset,
  input  wire logic [1:0]  size,
  input  wire logic        is_signed,
  output logic      [31:0] ext_data
);
  logic [31:0] shifted;   // Data shifted down so the addressed lane sits at bit zero.

  // Shift the addressed lane down, then extend it to the full word.
  always_comb begin
    shifted = raw_data >> {byte_offset, 3'h0};
    unique case (size)
      SIZE_BYTE: ext_data = {{24{is_signed & shifted[7]}}, shifted[7:0]};
      SIZE_HALF: ext_data = {{16{is_signed & shifted[15]}}, shifted[15:0]};
      default:   ext_data = shifted;
    endcase
  end
endmodule

// ==== core/ldst_ext_decode.sv ====
// Decoder and sequencer for the custom post-increment, indexed and event load/store instructions.
// Overview of operation
// RL1 - Access at old base, then write incremented base.
// RL2 - Base from register; immediate or register increment.
// RL3 - Custom forms only when extension parameter is 1.
// RL4 - Operands signed; immediates sign-extended.
// RL5 - Immediate post-increment loads use opcode 0001011.
// RL6 - Register post-increment loads use funct3 111.
// RL7 - Indexed loads use opcode 0000011, funct3 111.
// RL8 - Indexed load reads base plus offset, extended.
// RL9 - Immediate stores: opcode 0101011, split offset.
// RL10 - Immediate store writes source, base adds immediate.
// RL11 - Register post-increment stores: funct7 zero, 100-110.
// RL12 - Register store adds third register to base.
// RL13 - Indexed stores use opcode 0100011, offset bits 11:7.
// RL14 - Indexed store leaves base register unchanged.
// RL15 - Event load only with cluster parameter 1.
// RL16 - Event load loads word, may request sleep.
// RL17 - Event address is base plus sign-extended immediate.
// RL18 - Event load: opcode 0000011, funct3 110.
// RL19 - Extra writeback cycle for base, stalling issue.
// RL20 - Illegal exception when extension disabled.
module ldst_ext_decode
  import ldst_ext_pkg::*;
#(
  parameter bit custom_ext_enable_param = 1'b1,   // Enables the post-increment and indexed forms.
  parameter bit cluster_support_param   = 1'b1    // Enables the event load.
)
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  output logic             instr_ready,
  output logic             illegal_instr,
  output logic [4:0]       rs1_addr,
  output logic [4:0]       rs2_addr,
  output logic [4:0]       rs3_addr,
  input  wire logic [31:0] rs1_data,
  input  wire logic [31:0] rs2_data,
  input  wire logic [31:0] rs3_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_gnt,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  output logic             rf_we,
  output logic [4:0]       rf_waddr,
  output logic [31:0]      rf_wdata,
  output logic             sleep_req
);
  phase_t      phase, next_phase;           // Current execution phase.
  logic        is_store, next_is_store;     // Latched operation is a store.
  logic        post_inc, next_post_inc;     // Latched operation writes the base back.
  logic        is_event, next_is_event;     // Latched operation is the event load.
  logic        ld_signed, next_ld_signed;   // Sign-extend the load result.
  logic [1:0]  size, next_size;             // Latched access size.
  logic [4:0]  dest, next_dest;             // Load destination register.
  logic [4:0]  base_reg, next_base_reg;     // Base register index.
  logic [31:0] addr, next_addr;             // Latched access address.
  logic [31:0] new_base, next_new_base;     // Incremented base value waiting for writeback.
  logic [31:0] wdata, next_wdata;           // Latched store data, lane aligned.
  logic        req_sent, next_req_sent;     // Memory request has been granted.
  logic        illegal, next_illegal;       // One-cycle illegal instruction pulse.
  logic        wb_en, next_wb_en;           // Registered writeback strobe.
  logic [4:0]  wb_addr, next_wb_addr;       // Registered writeback address.
  logic [31:0] wb_data, next_wb_data;       // Registered writeback data.
  logic        sleep, next_sleep;           // Registered sleep request pulse.

  // Decoded fields of the incoming instruction.
  logic [6:0]  opc;
  logic [2:0]  f3;
  logic [6:0]  f7;
  logic [31:0] imm_i;        // Load immediate, sign extended.
  logic [31:0] imm_s;        // Split store immediate, sign extended.
  logic        dec_hit;      // Instruction is one of ours and is legal.
  logic        dec_custom;   // Instruction is one of the extension encodings.
  logic        dec_store;
  logic        dec_post;
  logic        dec_event;
  logic        dec_signed;
  logic [1:0]  dec_size;
  logic [31:0] dec_addr;
  logic [31:0] dec_incr;
  logic [31:0] load_ext;     // Extended load result.

  assign opc   = instr[6:0];
  assign f3    = instr[14:12];
  assign f7    = instr[31:25];
  assign imm_i = {{20{instr[31]}}, instr[31:20]};                 // RL4
  assign imm_s = {{20{instr[31]}}, instr[31:25], instr[11:7]};    // RL9 RL4

  // Register index outputs; rs3 is in bits 11:7 for the register stores.
  assign rs1_addr = instr[19:15];
  assign rs2_addr = instr[24:20];
  assign rs3_addr = instr[11:7];   // RL11 RL13

  // Decode one instruction into kind, size, address and increment.
  always_comb begin
    dec_custom = 1'b0;
    dec_store  = 1'b0;
    dec_post   = 1'b0;
    dec_event  = 1'b0;
    dec_signed = 1'b0;
    dec_size   = SIZE_WORD;
    dec_addr   = rs1_data;   // RL1 RL2
    dec_incr   = imm_i;
    if (opc == OPC_CUSTOM_LD && f3 != F3_REG) begin
      // Immediate post-increment loads.
      dec_post   = 1'b1;   // RL5
      dec_custom = (f3 == F3_LB) || (f3 == F3_LBU) || (f3 == F3_LH) || (f3 == F3_LHU) || (f3 == F3_LW);
      dec_signed = !f3[2];
      dec_size   = (f3[1:0] == 2'h0) ? SIZE_BYTE : (f3[1:0] == 2'h1) ? SIZE_HALF : SIZE_WORD;
    end else if ((opc == OPC_CUSTOM_LD || opc == OPC_LOAD) && f3 == F3_REG) begin
      // Register-offset loads, post-increment or indexed.
      dec_post   = (opc == OPC_CUSTOM_LD);   // RL6 RL7
      dec_custom = (f7 == F7_LB) || (f7 == F7_LBU) || (f7 == F7_LH) || (f7 == F7_LHU) || (f7 == F7_LW);
      dec_signed = !f7[5];
      dec_size   = (f7 == F7_LW) ? SIZE_WORD : f7[3] ? SIZE_HALF : SIZE_BYTE;
      dec_incr   = rs2_data;
      if (!dec_post) begin
        dec_addr = rs1_data + rs2_data;   // RL8
      end
    end else if (opc == OPC_CUSTOM_ST && f3 <= F3_LW) begin
      // Immediate post-increment stores.
      dec_custom = 1'b1;   // RL9
      dec_store  = 1'b1;
      dec_post   = 1'b1;
      dec_size   = f3[1:0];
      dec_incr   = imm_s;   // RL10
    end else if ((opc == OPC_CUSTOM_ST || opc == OPC_STORE) && f7 == F7_ZERO &&
                 (f3 == F3_SB_REG || f3 == F3_SH_REG || f3 == F3_SW_REG)) begin
      // Register-offset stores, post-increment or indexed.
      dec_custom = 1'b1;   // RL11 RL13
      dec_store  = 1'b1;
      dec_post   = (opc == OPC_CUSTOM_ST);
      dec_size   = f3[1:0] - 2'h0;
      dec_incr   = rs3_data;   // RL12
      if (!dec_post) begin
        dec_addr = rs1_data + rs3_data;   // RL14
      end
    end else if (opc == OPC_LOAD && f3 == F3_ELW) begin
      // Event load word.
      dec_event = 1'b1;   // RL18
      dec_addr  = rs1_data + imm_i;   // RL17
    end
    dec_hit = (dec_custom && custom_ext_enable_param) || (dec_event && cluster_support_param);   // RL3 RL15
  end

  // Store data is replicated across lanes; byte enables pick the lane.
  always_comb begin
    mem_be = 4'hf;
    unique case (size)
      SIZE_BYTE: mem_be = 4'h1 << addr[1:0];
      SIZE_HALF: mem_be = 4'h3 << {addr[1], 1'b0};
      default:   mem_be = 4'hf;
    endcase
  end

  ldst_extend u_extend (
    .raw_data    (mem_rdata),
    .byte_offset (addr[1:0]),
    .size        (size),
    .is_signed   (ld_signed),
    .ext_data    (load_ext)
  );

  // Sequencer: issue, memory phase, then for post-increment forms an extra cycle for the base writeback.
  always_comb begin
    next_phase     = phase;
    next_is_store  = is_store;
    next_post_inc  = post_inc;
    next_is_event  = is_event;
    next_ld_signed = ld_signed;
    next_size      = size;
    next_dest      = dest;
    next_base_reg  = base_reg;
    next_addr      = addr;
    next_new_base  = new_base;
    next_wdata     = wdata;
    next_req_sent  = req_sent;
    next_illegal   = 1'b0;
    next_wb_en     = 1'b0;
    next_wb_addr   = wb_addr;
    next_wb_data   = wb_data;
    next_sleep     = 1'b0;
    unique case (phase)
      st_idle: begin
        if (instr_valid && dec_hit) begin
          next_phase     = st_mem;
          next_is_store  = dec_store;
          next_post_inc  = dec_post;
          next_is_event  = dec_event;
          next_ld_signed = dec_signed;
          next_size      = dec_size;
          next_dest      = instr[11:7];
          next_base_reg  = instr[19:15];
          next_addr      = dec_addr;
          next_new_base  = rs1_data + dec_incr;   // RL1
          next_wdata     = (dec_size == SIZE_BYTE) ? {4{rs2_data[7:0]}} :
                           (dec_size == SIZE_HALF) ? {2{rs2_data[15:0]}} : rs2_data;   // RL10
          next_req_sent  = 1'b0;
        end else if (instr_valid && (dec_custom || dec_event)) begin
          // Disabled encodings trap instead of executing.
          next_illegal = 1'b1;   // RL20
        end
      end
      st_mem: begin
        if (mem_req && mem_gnt) begin
          next_req_sent = 1'b1;
        end
        if (is_store && mem_req && mem_gnt) begin
          next_phase = post_inc ? st_base_wb : st_idle;
        end else if (!is_store && req_sent && mem_rvalid) begin
          // Load data returns; destination is written first.
          next_wb_en   = 1'b1;
          next_wb_addr = dest;
          next_wb_data = load_ext;   // RL8 RL16
          next_sleep   = is_event;   // RL16
          next_phase   = post_inc ? st_base_wb : st_idle;
        end
      end
      st_base_wb: begin
        // Base writeback happens in its own cycle so one write port suffices.
        next_wb_en   = 1'b1;   // RL19
        next_wb_addr = base_reg;
        next_wb_data = new_base;   // RL1 RL12
        next_phase   = st_idle;
      end
      default: next_phase = st_idle;
    endcase
  end

  // Register all sequencer state; synchronous reset clears control.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      phase     <= st_idle;
      is_store  <= 1'b0;
      post_inc  <= 1'b0;
      is_event  <= 1'b0;
      ld_signed <= 1'b0;
      size      <= SIZE_WORD;
      dest      <= 5'h00;
      base_reg  <= 5'h00;
      addr      <= 32'h0000_0000;
      new_base  <= 32'h0000_0000;
      wdata     <= 32'h0000_0000;
      req_sent  <= 1'b0;
      illegal   <= 1'b0;
      wb_en     <= 1'b0;
      wb_addr   <= 5'h00;
      wb_data   <= 32'h0000_0000;
      sleep     <= 1'b0;
    end else begin
      phase     <= next_phase;
      is_store  <= next_is_store;
      post_inc  <= next_post_inc;
      is_event  <= next_is_event;
      ld_signed <= next_ld_signed;
      size      <= next_size;
      dest      <= next_dest;
      base_reg  <= next_base_reg;
      addr      <= next_addr;
      new_base  <= next_new_base;
      wdata     <= next_wdata;
      req_sent  <= next_req_sent;
      illegal   <= next_illegal;
      wb_en     <= next_wb_en;
      wb_addr   <= next_wb_addr;
      wb_data   <= next_wb_data;
      sleep     <= next_sleep;
    end
  end

  // Issue stalls while an instruction is in flight.
  assign instr_ready   = (phase == st_idle);   // RL19
  assign illegal_instr = illegal;
  assign mem_req       = (phase == st_mem) && !req_sent;
  assign mem_we        = is_store;
  assign mem_addr      = addr;
  assign mem_wdata     = wdata;
  assign rf_we         = wb_en;
  assign rf_waddr      = wb_addr;
  assign rf_wdata      = wb_data;
  assign sleep_req     = sleep;

  // Post-increment base writeback carries the latched incremented value.
  base_wb_value_a: assert property (@(posedge clock) disable iff (!reset_n) // RL1
    (phase == st_base_wb) |=> (rf_we && rf_waddr == base_reg && rf_wdata == $past(new_base)))
    else $error("Base writeback value wrong.");

  // Memory address is the old base for post-increment forms.
  post_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // RL2
    (phase == st_idle && instr_valid && dec_hit && dec_post) |=> (mem_addr == $past(rs1_data)))
    else $error("Post-increment address not base.");

  // Disabled extension never starts a custom access.
  ext_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // RL3
    (phase == st_idle && instr_valid && dec_custom && !custom_ext_enable_param) |=> (phase == st_idle))
    else $error("Custom instruction executed while disabled.");

  // Indexed load address is base plus offset.
  idx_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // RL8
    (phase == st_idle && instr_valid && dec_hit && opc == OPC_LOAD && f3 == F3_REG)
      |=> (mem_addr == $past(rs1_data) + $past(rs2_data) && !post_inc))
    else $error("Indexed load address wrong.");

  // Indexed stores go straight back to idle without a base write.
  idx_store_a: assert property (@(posedge clock) disable iff (!reset_n) // RL14
    (phase == st_mem && is_store && !post_inc && mem_req && mem_gnt) |=> (phase == st_idle) ##1 !rf_we)
    else $error("Indexed store modified base.");

  // Event load address uses the sign-extended immediate.
  event_addr_a: assert property (@(posedge clock) disable iff (!reset_n) // RL17
    (phase == st_idle && instr_valid && dec_hit && dec_event)
      |=> (mem_addr == $past(rs1_data) + {{20{$past(instr[31])}}, $past(instr[31:20])}))
    else $error("Event load address wrong.");

  // Sleep request only pulses with the event load's data writeback.
  sleep_pulse_a: assert property (@(posedge clock) disable iff (!reset_n) // RL16
    sleep_req |-> (rf_we && rf_waddr == dest))
    else $error("Sleep request without event load result.");

  // Issue stalls from the cycle after an instruction is taken, while its request goes out.
  issue_stall_a: assert property (@(posedge clock) disable iff (!reset_n) // RL19
    (instr_ready && instr_valid && dec_hit) |=> (!instr_ready && mem_req))
    else $error("Issue not stalled during sequence.");

  // Disabled encodings raise the illegal pulse the next cycle.
  illegal_raise_a: assert property (@(posedge clock) disable iff (!reset_n) // RL20
    (phase == st_idle && instr_valid && (dec_custom || dec_event) && !dec_hit) |=> illegal_instr)
    else $error("Illegal instruction not raised.");
endmodule

// ==== sim/data_mem_model.sv ====
// Behavioural data memory that answers the decode block's load and store requests.
module data_mem_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [2:0]  stall,
  output logic             mem_gnt,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];  // Word store, aliased over address bits 7:2 to stay small.
  logic [2:0]  gwait;     // Cycles left before the next grant.
  logic [2:0]  rwait;     // Cycles left before the pending read answers.
  logic        rpend;     // A granted read still waits for its data phase.
  logic [5:0]  ridx;      // Word index of the pending read.

  // Distinct words with both sign bits set in places, so extension slips show.
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'h9e37_79b9 * (i + 1);
    mem_rdata = 32'h0;
    mem_rvalid = 1'b0;
  end

  // The grant is combinational so that it lands in the request's own cycle; a prompt answer follows one cycle later.
  assign mem_gnt = mem_req && (gwait == 3'h0);

  // Grant, write and read sequencing; idle read data toggles so stale values never match.
  always @(posedge clock) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!reset_n) begin
      gwait <= 3'h0;
      rpend <= 1'b0;
    end else begin
      if (mem_req && mem_gnt) begin
        gwait <= stall;
        if (mem_we) begin
          for (int i = 0; i < 4; i++) if (mem_be[i]) mem[mem_addr[7:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
        end else if (stall == 3'h0) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= mem[mem_addr[7:2]];
        end else begin
          rpend <= 1'b1;
          ridx <= mem_addr[7:2];
          rwait <= stall - 3'h1;
        end
      end else if (mem_req) begin
        gwait <= gwait - 3'h1;
      end
      if (rpend && rwait == 3'h0) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= mem[ridx];
        rpend <= 1'b0;
      end else if (rpend) begin
        rwait <= rwait - 3'h1;
      end
    end
  end
endmodule

// ==== sim/post_increment_load_store_decode_tb.sv ====
// Self-checking bench for the custom load and store decode block.
module post_increment_load_store_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ldst_ext_pkg::*;
  localparam logic [6:0] F7_TAB [5] = '{F7_LB, F7_LBU, F7_LH, F7_LHU, F7_LW};
  localparam logic [2:0] F3_TAB [5] = '{F3_LB, F3_LBU, F3_LH, F3_LHU, F3_LW};
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        instr_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [2:0]  stall = 3'h0;  // Memory answer delay, zero whenever bit 4 of the run's draw is set.
  logic        instr_ready, illegal_instr, mem_req, mem_we, mem_gnt, mem_rvalid, rf_we, sleep_req;
  logic [4:0]  rs1_addr, rs2_addr, rs3_addr, rf_waddr;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rf_wdata;
  logic [31:0] seed = 32'h0000_000a;
  logic [3:0]  mem_be;
  logic [31:0] rf [32];       // Register file, read combinationally by both instances.
  logic        off_illegal, off_req, off_we;
  int          bad_count, checks, cycles, wr_cnt, slp_cnt, ill_cnt, off_ill, off_act, req_cnt;

  always #25 clock = ~clock;

  ldst_ext_decode u_ldst_ext_decode (
    .clock, .reset_n, .instr_valid, .instr, .instr_ready, .illegal_instr, .rs1_addr, .rs2_addr, .rs3_addr,
    .rs1_data(rf[rs1_addr]), .rs2_data(rf[rs2_addr]), .rs3_data(rf[rs3_addr]), .mem_req, .mem_we, .mem_addr,
    .mem_be, .mem_wdata, .mem_gnt, .mem_rvalid, .mem_rdata, .rf_we, .rf_waddr, .rf_wdata, .sleep_req);

  // Same stream into a build with both extensions off; it must trap and stay quiet.
  ldst_ext_decode #(.custom_ext_enable_param(1'b0), .cluster_support_param(1'b0)) u_ldst_ext_decode_off (
    .clock, .reset_n, .instr_valid, .instr, .instr_ready(), .illegal_instr(off_illegal), .rs1_addr(),
    .rs2_addr(), .rs3_addr(), .rs1_data(rf[rs1_addr]), .rs2_data(rf[rs2_addr]), .rs3_data(rf[rs3_addr]),
    .mem_req(off_req), .mem_we(), .mem_addr(), .mem_be(), .mem_wdata(), .mem_gnt(1'b0), .mem_rvalid(1'b0),
    .mem_rdata(32'h0), .rf_we(off_we), .rf_waddr(), .rf_wdata(), .sleep_req());

  data_mem_model u_data_mem_model (
    .clock, .reset_n, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .stall, .mem_gnt, .mem_rvalid, .mem_rdata);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Register writes and event counters; also cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (rf_we) begin
      rf[rf_waddr] <= rf_wdata;
      wr_cnt++;
    end
    if (sleep_req) slp_cnt++;
    if (sleep_req) check("sleep_with_write", rf_we, 1'b1);
    if (illegal_instr) ill_cnt++;
    if (off_illegal) off_ill++;
    if (off_req || off_we) off_act++;
    if (mem_req && mem_gnt) req_cnt++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction

  // Several steps per draw, so that neighbouring draws are not plain shifts of each other.
  task automatic rnd(output logic [31:0] r);
    repeat (7) seed = lfsr_next(seed);
    r = seed;
  endtask

  function automatic logic [31:0] extend(input logic [31:0] w, input logic [1:0] off, input logic [1:0] sz,
                                         input bit sgn);
    logic [31:0] s;
    s = w >> (8 * off);
    if (sz == SIZE_BYTE) return {{24{sgn & s[7]}}, s[7:0]};
    if (sz == SIZE_HALF) return {{16{sgn & s[15]}}, s[15:0]};
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [1:0] off,
                                        input logic [1:0] sz);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) if (i >= off && i < off + (1 << sz)) m[8*i +: 8] = d[8*(i-off) +: 8];
    return m;
  endfunction

  // Builds one instruction of kind k; base, source and offset registers never overlap.
  task automatic gen(input int k, input int sel, output logic [31:0] ins);
    logic [31:0] r, s;
    logic [4:0]  a, b, c;
    rnd(r);
    rnd(s);
    a = {2'b00, r[2:0]} + 5'h1;
    b = {2'b01, r[5:3]} + 5'h1;
    c = {2'b10, r[8:6]} + 5'h1;
    rf[b] = (k < 3) ? {s[31:2], 2'b00} : s;  // Load offsets stay word multiples to keep accesses aligned.
    rf[c] = {r[31:2], 2'b00};
    case (k)
      0: ins = {s[31:22], 2'b00, a, F3_TAB[sel], c, OPC_CUSTOM_LD};
      1: ins = {F7_TAB[sel], b, a, F3_REG, c, OPC_CUSTOM_LD};
      2: ins = {F7_TAB[sel], b, a, F3_REG, c, OPC_LOAD};
      3: ins = {s[31:25], b, a, 3'(sel % 3), s[4:2], 2'b00, OPC_CUSTOM_ST};
      4: ins = {F7_ZERO, b, a, 3'(sel % 3 + 4), c, OPC_CUSTOM_ST};
      5: ins = {F7_ZERO, b, a, 3'(sel % 3 + 4), c, OPC_STORE};
      default: ins = {s[31:22], 2'b00, a, F3_ELW, c, OPC_LOAD};
    endcase
  endtask

  // Issues one instruction, waits for completion and compares every effect.
  task automatic run(input logic [31:0] ins, input bit known);
    logic [4:0]  a, b, c;
    logic [1:0]  sz;
    logic [31:0] r, inc, base, addr, old, dat;
    bit          ld, post;
    int          w0, s0, i0, d0, q0, n;
    a = ins[19:15];
    b = ins[24:20];
    c = ins[11:7];
    ld = (ins[6:0] == OPC_CUSTOM_LD) || (ins[6:0] == OPC_LOAD);
    post = (ins[6:0] == OPC_CUSTOM_LD) || (ins[6:0] == OPC_CUSTOM_ST);
    sz = (ld && ins[14:12] == F3_REG) ? ins[29:28] : ins[13:12];
    rnd(r);
    rf[a] = {r[31:2], r[1:0] & ~((2'h1 << sz) - 2'h1)};
    if (ld) inc = (ins[14:12] == F3_REG) ? rf[b] : {{20{ins[31]}}, ins[31:20]};
    else inc = ins[14] ? rf[c] : {{20{ins[31]}}, ins[31:25], ins[11:7]};
    base = rf[a];
    addr = post ? base : base + inc;
    old = u_data_mem_model.mem[addr[7:2]];
    dat = extend(old, addr[1:0], sz, (ins[14:12] == F3_REG) ? !ins[30] : !ins[14]);
    {w0, s0, i0, d0, q0} = {wr_cnt, slp_cnt, ill_cnt, off_ill, req_cnt};
    stall = r[4] ? 3'h0 : r[7:5];
    check("ready", instr_ready, 1'b1);
    instr = ins;
    instr_valid = 1'b1;
    @(posedge clock);
    #1 instr_valid = 1'b0;
    n = 0;
    while (instr_ready !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    #1;
    if (!known) begin
      check("ignored", wr_cnt - w0 + req_cnt - q0 + ill_cnt - i0, 0);
      return;
    end
    if (ld) check("dest", rf[c], (post && c == a) ? base + inc : dat);
    else check("memory", u_data_mem_model.mem[addr[7:2]], merge(old, rf[b], addr[1:0], sz));
    check("base", rf[a], post ? base + inc : base);
    check("address", mem_addr, addr);
    check("requests", req_cnt - q0, 1);
    check("writes", wr_cnt - w0, ld ? (post ? 2 : 1) : (post ? 1 : 0));
    check("sleep", slp_cnt - s0, (ins[6:0] == OPC_LOAD && ins[14:12] == F3_ELW) ? 1 : 0);
    check("illegal", ill_cnt - i0, 0);
    check("disabled_trap", off_ill - d0, 1);
    check("disabled_quiet", off_act, 0);
  endtask

  // Every encoding at least once, then awkward corners, then a seeded random mix.
  initial begin
    logic [31:0] ins, r;
    for (int i = 0; i < 32; i++) rf[i] = 32'h0;
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    for (int k = 0; k < 7; k++) begin
      for (int s = 0; s < ((k inside {[3:5]}) ? 3 : 5); s++) begin
        gen(k, s, ins);
        run(ins, 1'b1);
      end
    end
    $display("test every_encoding done, checks %0d", checks);
    gen(0, 4, ins);
    ins[11:7] = ins[19:15];  // Destination equal to base: base write lands last.
    run(ins, 1'b1);
    gen(1, 0, ins);
    ins[31:25] = 7'h7f;      // Unlisted width code is ignored.
    run(ins, 1'b0);
    gen(3, 2, ins);
    ins[31:25] = 7'h40;      // Most negative split immediate region.
    ins[11:7] = 5'h1c;
    run(ins, 1'b1);
    $display("test corners done, checks %0d", checks);
    repeat (200) begin
      rnd(r);
      gen(r[5:3] % 7, r[10:8] % 5, ins);
      run(ins, 1'b1);
    end
    $display("test random_mix done, checks %0d", checks);
    end_of_test();
  end
endmodule
